// >>> core/pes_top.v
// performance event selection with two general counters on a wishbone slave
`timescale 1ns/1ps
`include "pes_defs.vh"

// Contract
// - event 08H mask 08H counts every store data-TLB miss, speculative ones too.
// - store misses come from the second-level data translation buffer.
// - event 09H mask 01H adds one per disambiguation recovery cycle.
// - event 09H mask 02H counts each successfully disambiguated load.
// - event 0CH mask 01H counts page walks from data or instruction TLB misses.
// - event 0CH mask 02H adds one per cycle a page walk runs.
// - event 11H mask 00H counts SIMD floating-point microcode assists.
// - assist event also counts x87 cases; only counter one counts it.
// - event 12H mask 00H counts integer and float multiplies; counter one only.
module pes_top #(
  parameter CNT_W = 32
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // data translation and page walker sources
  input wire second_level_data_xlate_buffer_store_miss_i,
  input wire walk_start_data_i,
  input wire walk_start_instr_i,
  input wire walk_busy_i,
  // load ordering sources
  input wire disamb_recovery_i,
  input wire load_order_success_event_i,
  // floating point assist sources
  input wire denormal_input_zeroing_flag_i,
  input wire underflow_result_zeroing_flag_i,
  input wire simd_denormal_in_i,
  input wire simd_underflow_i,
  input wire x87_nan_denorm_load_i,
  input wire x87_div_zero_i,
  input wire x87_underflow_i,
  // multiplier sources
  input wire int_mult_i,
  input wire fp_mult_i,
  // counter values
  output wire [CNT_W-1:0] general_counter_zero_o,
  output wire [CNT_W-1:0] general_counter_one_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function [31:0] pes_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer i;
    begin
      pes_merge = old_v;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (be[i])
        begin
          pes_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // true when a write is taken at the given register offset
  function pes_hit;
    input take;
    input [7:0] adr;
    input [7:0] off;
    begin
      pes_hit = take && (adr == off);
    end
  endfunction

  // ****************************************************************
  // event reduction
  // ****************************************************************
  reg [31:0] sel0_q;
  reg [31:0] sel1_q;
  reg [CNT_W-1:0] cnt0_q;
  reg [CNT_W-1:0] cnt1_q;
  reg [CNT_W-1:0] cnt0_d;
  reg [CNT_W-1:0] cnt1_d;
  reg [31:0] rdata_d;
  wire [1:0] inc0;
  wire [1:0] inc1;
  wire valid0;
  wire valid1;
  wire store_miss;
  wire assist;
  wire [1:0] walk_starts;
  wire [1:0] mults;
  wire req;
  wire wr;
  wire [7:0] word_adr;
  wire wr_sel0;
  wire wr_sel1;
  wire wr_cnt0;
  wire wr_cnt1;

  // the second-level buffer is where store translation happens
  assign store_miss = second_level_data_xlate_buffer_store_miss_i;
  // one assist per operation, so the causes are merged rather than summed
  assign assist = (simd_denormal_in_i & ~denormal_input_zeroing_flag_i)
                | (simd_underflow_i & ~underflow_result_zeroing_flag_i)
                | x87_nan_denorm_load_i | x87_div_zero_i | x87_underflow_i;
  // both walkers may start in one cycle, each walk counts
  assign walk_starts = {1'b0, walk_start_data_i} + {1'b0, walk_start_instr_i};
  assign mults = {1'b0, int_mult_i} + {1'b0, fp_mult_i};

  // ****************************************************************
  // event decoders
  // ****************************************************************
  pes_event_mux #(
    .CTR_IDX(0)
  ) u_mux0 (
    .evt_i(sel0_q[`PES_SEL_EVT_LSB +: 8]),
    .umask_i(sel0_q[`PES_SEL_UMASK_LSB +: 8]),
    .en_i(sel0_q[`PES_SEL_EN_BIT]),
    .store_miss_i(store_miss),
    .recovery_i(disamb_recovery_i),
    .load_ok_i(load_order_success_event_i),
    .walk_start_i(walk_starts),
    .walk_busy_i(walk_busy_i),
    .assist_i(assist),
    .mult_i(mults),
    .inc_o(inc0),
    .valid_o(valid0)
  );

  pes_event_mux #(
    .CTR_IDX(1)
  ) u_mux1 (
    .evt_i(sel1_q[`PES_SEL_EVT_LSB +: 8]),
    .umask_i(sel1_q[`PES_SEL_UMASK_LSB +: 8]),
    .en_i(sel1_q[`PES_SEL_EN_BIT]),
    .store_miss_i(store_miss),
    .recovery_i(disamb_recovery_i),
    .load_ok_i(load_order_success_event_i),
    .walk_start_i(walk_starts),
    .walk_busy_i(walk_busy_i),
    .assist_i(assist),
    .mult_i(mults),
    .inc_o(inc1),
    .valid_o(valid1)
  );

  // ****************************************************************
  // bus decode and counters
  // ****************************************************************
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i;
  assign word_adr = {adr_i[7:2], 2'b00};
  assign wr_sel0 = pes_hit(wr, word_adr, `PES_OFF_SEL0);
  assign wr_sel1 = pes_hit(wr, word_adr, `PES_OFF_SEL1);
  assign wr_cnt0 = pes_hit(wr, word_adr, `PES_OFF_CNT0);
  assign wr_cnt1 = pes_hit(wr, word_adr, `PES_OFF_CNT1);

  always @*
  begin
    // a software write to a counter wins over that cycle's increment
    cnt0_d = cnt0_q + {{(CNT_W-2){1'b0}}, inc0};
    cnt1_d = cnt1_q + {{(CNT_W-2){1'b0}}, inc1};
    if (wr_cnt0)
    begin
      cnt0_d = pes_merge(cnt0_q, dat_i, sel_i);
    end
    if (wr_cnt1)
    begin
      cnt1_d = pes_merge(cnt1_q, dat_i, sel_i);
    end
  end

  always @*
  begin
    case (word_adr)
      `PES_OFF_SEL0: rdata_d = sel0_q;
      `PES_OFF_SEL1: rdata_d = sel1_q;
      `PES_OFF_CNT0: rdata_d = cnt0_q;
      `PES_OFF_CNT1: rdata_d = cnt1_q;
      `PES_OFF_STAT: rdata_d = {30'h0, valid1, valid0};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel0_q <= `PES_SEL_RST;
      sel1_q <= `PES_SEL_RST;
      cnt0_q <= `PES_CNT_RST;
      cnt1_q <= `PES_CNT_RST;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= req;
      cnt0_q <= cnt0_d;
      cnt1_q <= cnt1_d;
      if (req && !we_i)
      begin
        dat_o <= rdata_d;
      end
      if (wr_sel0)
      begin
        sel0_q <= pes_merge(sel0_q, dat_i, sel_i);
      end
      if (wr_sel1)
      begin
        sel1_q <= pes_merge(sel1_q, dat_i, sel_i);
      end
    end
  end

  assign general_counter_zero_o = cnt0_q;
  assign general_counter_one_o = cnt1_q;

endmodule

// >>> core/pes_defs.vh
// constants for the performance event selection block
`ifndef PES_DEFS_VH
`define PES_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PES_OFF_SEL0 8'h00
`define PES_OFF_SEL1 8'h04
`define PES_OFF_CNT0 8'h08
`define PES_OFF_CNT1 8'h0C
`define PES_OFF_STAT 8'h10

// ****************************************************************
// select register fields and reset values
// ****************************************************************
`define PES_SEL_EVT_LSB 0
`define PES_SEL_UMASK_LSB 8
`define PES_SEL_EN_BIT 22
`define PES_SEL_RST 32'h00000000
`define PES_CNT_RST 32'h00000000

// ****************************************************************
// event numbers and unit masks
// ****************************************************************
`define PES_EV_DTLB 8'h08
`define PES_EV_DISAMB 8'h09
`define PES_EV_WALK 8'h0C
`define PES_EV_FPA 8'h11
`define PES_EV_MULT 8'h12
`define PES_UM_NONE 8'h00
`define PES_UM_STORE 8'h08
`define PES_UM_RESET 8'h01
`define PES_UM_SUCCESS 8'h02
`define PES_UM_COUNT 8'h01
`define PES_UM_CYCLES 8'h02

`endif

// >>> core/pes_event_mux.v
// event number and unit mask decoder for one general counter
`timescale 1ns/1ps
`include "pes_defs.vh"

module pes_event_mux #(
  parameter CTR_IDX = 0
) (
  // selection
  input wire [7:0] evt_i,
  input wire [7:0] umask_i,
  input wire en_i,
  // event sources, already reduced to per-cycle amounts
  input wire store_miss_i,
  input wire recovery_i,
  input wire load_ok_i,
  input wire [1:0] walk_start_i,
  input wire walk_busy_i,
  input wire assist_i,
  input wire [1:0] mult_i,
  // result
  output reg [1:0] inc_o,
  output reg valid_o
);

  always @*
  begin
    inc_o = 2'h0;
    valid_o = 1'b1;
    case ({evt_i, umask_i})
      {`PES_EV_DTLB, `PES_UM_STORE}: inc_o = {1'b0, store_miss_i};
      {`PES_EV_DISAMB, `PES_UM_RESET}: inc_o = {1'b0, recovery_i};
      {`PES_EV_DISAMB, `PES_UM_SUCCESS}: inc_o = {1'b0, load_ok_i};
      {`PES_EV_WALK, `PES_UM_COUNT}: inc_o = walk_start_i;
      {`PES_EV_WALK, `PES_UM_CYCLES}: inc_o = {1'b0, walk_busy_i};
      {`PES_EV_FPA, `PES_UM_NONE}:
      begin
        // restricted event: no count on the other counter
        valid_o = (CTR_IDX == 1);
        inc_o = (CTR_IDX == 1) ? {1'b0, assist_i} : 2'h0;
      end
      {`PES_EV_MULT, `PES_UM_NONE}:
      begin
        valid_o = (CTR_IDX == 1);
        inc_o = (CTR_IDX == 1) ? mult_i : 2'h0;
      end
      default:
        valid_o = 1'b0;
    endcase
    if (!en_i)
    begin
      inc_o = 2'h0;
    end
  end

endmodule

// >>> sim/pes_top_assertions.sv
// port-level checks for the event selection block
`timescale 1ns/1ps
module pes_top_chk #(
  parameter CNT_W = 32
) (
  // clock, reset and bus
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  // counters
  input wire [CNT_W-1:0] general_counter_zero_o,
  input wire [CNT_W-1:0] general_counter_one_o
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_ack_when_idle: assert property (!$past(stb_i) |-> !ack_o)
    else $error("ack while bus idle");
  a_reset_ack_low: assert property ($fell(rst_i) |-> !ack_o)
    else $error("ack high after reset");
  a_cnt_reset_zero: assert property ($fell(rst_i) |-> general_counter_zero_o == 0 &&
    general_counter_one_o == 0) else $error("counter not cleared");
  a_cnt0_step_max: assert property (!$past(cyc_i) && !$past(cyc_i, 2) |->
    general_counter_zero_o - $past(general_counter_zero_o) <= 2) else $error("counter0 jump");
  a_cnt1_step_max: assert property (!$past(cyc_i) && !$past(cyc_i, 2) |->
    general_counter_one_o - $past(general_counter_one_o) <= 2) else $error("counter1 jump");
  c_read: cover property (ack_o);
  c_cnt0: cover property (!cyc_i ##1 general_counter_zero_o != $past(general_counter_zero_o));
  c_cnt1: cover property (!cyc_i ##1 general_counter_one_o != $past(general_counter_one_o));
endmodule
bind pes_top pes_top_chk #(.CNT_W(CNT_W)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .general_counter_zero_o, .general_counter_one_o);

// >>> sim/pes_core_model.sv
// core-side model that raises event lines for a number of cycles
`timescale 1ns/1ps
module pes_core_model (
  // clock
  input wire clk_i,
  // event lines towards the block
  output logic [14:0] ev_o
);
  initial ev_o = 15'h0;
  // lines return to idle after each burst, as the pipeline does
  task automatic drive(input logic [14:0] v, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      ev_o <= v;
    end
    @(posedge clk_i);
    ev_o <= 15'h0;
  endtask
endmodule

// >>> sim/pes_top_tb.sv
// self-checking bench for the event selection block
`timescale 1ns/1ps
module pes_top_tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic we_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, c0, c1, rdat;
  logic ack_o;
  logic [14:0] ev;
  int n_mismatch = 0;
  int check_count = 0;
  pes_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .second_level_data_xlate_buffer_store_miss_i(ev[0]), .walk_start_data_i(ev[1]),
    .walk_start_instr_i(ev[2]), .walk_busy_i(ev[3]), .disamb_recovery_i(ev[4]),
    .load_order_success_event_i(ev[5]), .denormal_input_zeroing_flag_i(ev[6]),
    .underflow_result_zeroing_flag_i(ev[7]), .simd_denormal_in_i(ev[8]),
    .simd_underflow_i(ev[9]), .x87_nan_denorm_load_i(ev[10]), .x87_div_zero_i(ev[11]),
    .x87_underflow_i(ev[12]), .int_mult_i(ev[13]), .fp_mult_i(ev[14]),
    .general_counter_zero_o(c0), .general_counter_one_o(c1));
  pes_core_model u_core (.clk_i, .ev_o(ev));
  initial forever #10 clk_i = ~clk_i;
  // ****
  // shared tasks
  // ****
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // select {mask, event} on counter c, count a burst, read back
  task automatic run(input int c, input logic [15:0] s, input logic [14:0] v, input int n,
    input logic [31:0] e);
    bus(1, 8'(c * 4), {9'h000, 1'b1, 6'h00, s});
    bus(1, 8'(8 + c * 4), 32'h0);
    u_core.drive(v, n);
    repeat (3) @(posedge clk_i);
    chk("port", e, (c == 0) ? c0 : c1);
    bus(0, 8'(8 + c * 4), 32'h0);
    chk("count", e, rdat);
    bus(1, 8'(c * 4), 32'h0);
  endtask
  // ****
  // scenarios
  // ****
  task t_regs;
    bus(1, 8'h14, 32'hFFFFFFFF);
    bus(1, 8'h10, 32'hFFFFFFFF);
    bus(0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rdat);
    bus(0, 8'h10, 32'h0);
    chk("status", 32'h0, rdat);
    // byte enables merge into the stored counter word
    bus(1, 8'h0C, 32'h11223344);
    sel_i <= 4'h6;
    bus(1, 8'h0C, 32'hAABBCCDD);
    sel_i <= 4'hF;
    bus(0, 8'h0C, 32'h0);
    chk("merge", 32'h11BBCC44, rdat);
    chk("port", 32'h11BBCC44, c1);
    $display("test regs done");
  endtask
  task t_events;
    run(0, 16'h0808, 15'h0001, 5, 5);
    run(1, 16'h0109, 15'h0010, 4, 4);
    run(0, 16'h0209, 15'h0020, 3, 3);
    run(0, 16'h010C, 15'h0006, 3, 6);
    run(1, 16'h020C, 15'h0008, 7, 7);
    run(1, 16'h0011, 15'h0300, 2, 2);
    run(1, 16'h0011, 15'h03C0, 3, 0);
    run(1, 16'h0011, 15'h1C00, 3, 3);
    run(1, 16'h0012, 15'h6000, 4, 8);
    $display("test events done");
  endtask
  task t_restrict;
    run(0, 16'h0012, 15'h6000, 4, 0);
    run(0, 16'h0011, 15'h1C00, 3, 0);
    run(1, 16'h0108, 15'h0001, 3, 0);
    run(0, 16'h0808, 15'h0006, 3, 0);
    bus(1, 8'h00, 32'h12);
    bus(1, 8'h04, 32'h12);
    bus(0, 8'h10, 32'h0);
    chk("status", 32'h2, rdat);
    $display("test restrict done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    t_regs;
    t_events;
    t_restrict;
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict;
  end
endmodule
